/* rtl/dcs_status.v */
// status reporting registers of a 12-channel dma controller
// What this block does
// RULE1 - done flag reads selected channel's completion
// RULE2 - writing one clears selected completion flag
// RULE3 - fault flag reads selected channel's error
// RULE4 - writing one clears selected error flag
// RULE5 - id holds lowest channel with interrupt
// RULE6 - id refreshes on lower channel or clear
// RULE7 - id reads zero when nothing pending
// RULE8 - writing id selects channel for access
// RULE9 - summary bit set per pending channel
// RULE10 - summary bit clears when disabled or cleared
// RULE11 - busy bit sets when transfer starts
// RULE12 - busy clears on done, error, disable
// RULE13 - waiting bit tracks pending transfer
// RULE14 - writing one clears selected suspend flag
// RULE15 - vectors read only, zero after reset
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "dcs_map.vh"
module dcs_status (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire [11:0] set_done,
    input wire [11:0] set_fault,
    input wire [11:0] set_suspend_flag,
    input wire [11:0] irq_en,
    input wire [11:0] xfer_start,
    input wire [11:0] act_done,
    input wire [11:0] bus_err,
    input wire [11:0] ch_disable,
    input wire [11:0] pend_set,
    input wire [11:0] trig_start,
    input wire [11:0] fetch_err,
    output reg [11:0] channel_irq_bits,
    output reg [11:0] channel_active_bits,
    output reg [11:0] channel_waiting_bits
);
    // ----------------------------------------
    // lowest-set-bit encoder
    // ----------------------------------------
    function [3:0] lowest;
        input [11:0] v;
        integer i;
        begin
            lowest = `DCS_RST_ID;
            for (i = 11; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    lowest = i[3:0];
                end
            end
        end
    endfunction

    function [11:0] onehot;
        input [3:0] n;
        begin
            onehot = (n < 4'hc) ? (12'h001 << n) : 12'h000;
        end
    endfunction

    // ----------------------------------------
    // channel flags
    // ----------------------------------------
    reg [3:0] sel_q;
    reg sel_man_q;
    wire wr_lci = wr & (addr == `DCS_OFF_LCI);
    wire [11:0] sel_oh = onehot(sel_q);
    wire [11:0] done_v, fault_v, suspend_flag_v, act_v, wait_v, irq_v;
    wire [11:0] clr_done = (wr_lci & wdata[`DCS_BIT_TDONE]) ? sel_oh : 12'h000;
    wire [11:0] clr_fault = (wr_lci & wdata[`DCS_BIT_TFAULT]) ? sel_oh : 12'h000;
    wire [11:0] clr_suspend_flag = (wr_lci & wdata[`DCS_BIT_SUSPEND_FLAG]) ? sel_oh : 12'h000;

    genvar g;
    generate
        for (g = 0; g < `DCS_NCH; g = g + 1) begin : g_ch
            dcs_chan_bit u_ch (
                .clk(clk),
                .rstn(rstn),
                .ce(ce),
                .set_done(set_done[g]),
                .set_fault(set_fault[g]),
                .set_suspend_flag(set_suspend_flag[g]),
                .clr_done(clr_done[g]),
                .clr_fault(clr_fault[g]),
                .clr_suspend_flag(clr_suspend_flag[g]),
                .irq_en(irq_en[g]),
                .xfer_start(xfer_start[g]), // RULE11
                .act_done(act_done[g]),
                .bus_err(bus_err[g]),
                .ch_disable(ch_disable[g]),
                .pend_set(pend_set[g]),
                .trig_start(trig_start[g]),
                .done_q(done_v[g]),
                .fault_q(fault_v[g]),
                .suspend_flag_q(suspend_flag_v[g]),
                .active_q(act_v[g]),
                .waiting_q(wait_v[g]),
                .irq(irq_v[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // channel selection
    // ----------------------------------------
    // software selection sticks until the chosen channel has nothing
    // pending, then the lowest pending channel is reported again
    wire [11:0] any_v = done_v | fault_v | suspend_flag_v;
    wire [3:0] low_id = lowest(any_v); // RULE5 RULE6 RULE7
    wire sel_live = |(any_v & sel_oh);
    reg [11:0] ferr_q;

    always @(posedge clk) begin
        if (!rstn) begin
            sel_q <= `DCS_RST_ID;
            sel_man_q <= 1'b0;
            ferr_q <= `DCS_RST_VEC;
        end else if (ce) begin
            ferr_q <= fetch_err | (ferr_q & ~ch_disable);
            if (wr_lci) begin
                sel_q <= wdata[`DCS_ID_MSB:0]; // RULE8
                sel_man_q <= 1'b1;
            end else if (sel_man_q & sel_live) begin
                sel_q <= sel_q;
            end else begin
                sel_q <= low_id; // RULE6
                sel_man_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    reg [31:0] rd_d;
    always @* begin
        rd_d = `DCS_RST_WORD;
        case (addr)
            `DCS_OFF_LCI: begin
                rd_d[`DCS_BIT_PEND] = |(wait_v & sel_oh);
                rd_d[`DCS_BIT_BUSY] = |(act_v & sel_oh);
                rd_d[`DCS_BIT_FERR] = |(ferr_q & sel_oh);
                rd_d[`DCS_BIT_SUSPEND_FLAG] = |(suspend_flag_v & sel_oh);
                rd_d[`DCS_BIT_TDONE] = |(done_v & sel_oh); // RULE1
                rd_d[`DCS_BIT_TFAULT] = |(fault_v & sel_oh); // RULE3
                // zero when no channel is pending
                rd_d[`DCS_ID_MSB:0] = (|any_v) ? sel_q : `DCS_RST_ID; // RULE7
            end
            `DCS_OFF_SUM: rd_d[11:0] = irq_v; // RULE9
            `DCS_OFF_BUSY: rd_d[11:0] = act_v;
            `DCS_OFF_WAIT: rd_d[11:0] = wait_v;
            default: rd_d = `DCS_RST_WORD;
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            rdata <= `DCS_RST_WORD;
            channel_irq_bits <= `DCS_RST_VEC; // RULE15
            channel_active_bits <= `DCS_RST_VEC;
            channel_waiting_bits <= `DCS_RST_VEC;
        end else if (ce) begin
            // vectors have no write path at all
            rdata <= rd ? rd_d : `DCS_RST_WORD; // RULE15
            channel_irq_bits <= irq_v;
            channel_active_bits <= act_v;
            channel_waiting_bits <= wait_v;
        end
    end
endmodule // dcs_status

/* include/dcs_map.vh */
// register offsets, field positions and reset values for the channel status block
`ifndef DCS_MAP_VH
`define DCS_MAP_VH
`define DCS_NCH 12
`define DCS_ADDR_W 8
`define DCS_OFF_LCI 8'h20
`define DCS_OFF_SUM 8'h24
`define DCS_OFF_BUSY 8'h28
`define DCS_OFF_WAIT 8'h2c
`define DCS_BIT_PEND 15
`define DCS_BIT_BUSY 14
`define DCS_BIT_FERR 13
`define DCS_BIT_SUSPEND_FLAG 10
`define DCS_BIT_TDONE 9
`define DCS_BIT_TFAULT 8
`define DCS_ID_MSB 3
`define DCS_RST_WORD 32'h0000_0000
`define DCS_RST_VEC 12'h000
`define DCS_RST_ID 4'h0
`endif

/* rtl/dcs_chan_bit.v */
// one channel's interrupt flags and activity bits
`timescale 1ns/1ns
module dcs_chan_bit (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire set_done,
    input wire set_fault,
    input wire set_suspend_flag,
    input wire clr_done,
    input wire clr_fault,
    input wire clr_suspend_flag,
    input wire irq_en,
    input wire xfer_start,
    input wire act_done,
    input wire bus_err,
    input wire ch_disable,
    input wire pend_set,
    input wire trig_start,
    output reg done_q,
    output reg fault_q,
    output reg suspend_flag_q,
    output reg active_q,
    output reg waiting_q,
    output wire irq
);
    always @(posedge clk) begin
        if (!rstn) begin
            done_q <= 1'b0;
            fault_q <= 1'b0;
            suspend_flag_q <= 1'b0;
            active_q <= 1'b0;
            waiting_q <= 1'b0;
        end else if (ce) begin
            // set wins over a same-cycle clear
            done_q <= set_done | (done_q & ~clr_done); // RULE2
            fault_q <= set_fault | (fault_q & ~clr_fault); // RULE4
            suspend_flag_q <= set_suspend_flag | (suspend_flag_q & ~clr_suspend_flag); // RULE14
            // start wins over a same-cycle end
            active_q <= xfer_start | (active_q & ~(act_done | bus_err | ch_disable)); // RULE12
            waiting_q <= pend_set | (waiting_q & ~(trig_start | bus_err | ch_disable)); // RULE13
        end
    end
    assign irq = irq_en & (done_q | fault_q | suspend_flag_q); // RULE10
endmodule // dcs_chan_bit

/* verif/dcs_status_assertions.sv */
// assertions on the dma channel status block ports
`timescale 1ns/1ns
module dcs_status_chk (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire [7:0] addr,
    input wire rd,
    input wire [31:0] rdata,
    input wire [11:0] irq_en,
    input wire [11:0] xfer_start,
    input wire [11:0] act_done,
    input wire [11:0] bus_err,
    input wire [11:0] ch_disable,
    input wire [11:0] pend_set,
    input wire [11:0] trig_start,
    input wire [11:0] channel_irq_bits,
    input wire [11:0] channel_active_bits,
    input wire [11:0] channel_waiting_bits
);
    // ----
    // outputs lag the event by two edges
    // ----
    wire go = ce & rstn;
    wire [11:0] b_clr = act_done | bus_err | ch_disable;
    wire [11:0] w_clr = trig_start | bus_err | ch_disable;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_busy_sets: assert property ($past(go, 2) && $past(go) && $past(b_clr) == 12'h0
        |-> (channel_active_bits & $past(xfer_start, 2)) == $past(xfer_start, 2))
        else $error("busy set");
    a_busy_clrs: assert property ($past(go, 2) && $past(go)
        && ($past(xfer_start, 2) | $past(xfer_start)) == 12'h0
        |-> (channel_active_bits & $past(b_clr, 2)) == 12'h0) else $error("busy clear");
    a_wait_sets: assert property ($past(go, 2) && $past(go) && $past(w_clr) == 12'h0
        |-> (channel_waiting_bits & $past(pend_set, 2)) == $past(pend_set, 2))
        else $error("wait set");
    a_wait_clrs: assert property ($past(go, 2) && $past(go)
        && ($past(pend_set, 2) | $past(pend_set)) == 12'h0
        |-> (channel_waiting_bits & $past(w_clr, 2)) == 12'h0) else $error("wait clear");
    a_irq_off: assert property ((go && irq_en == 12'h0) [*3]
        |-> channel_irq_bits == 12'h0) else $error("irq off");
    a_rd_idle: assert property (go && !rd |=> rdata == 32'h0) else $error("rdata idle");
    a_rd_unmapped: assert property (go && rd && !(addr inside {8'h20, 8'h24, 8'h28, 8'h2c})
        |=> rdata == 32'h0) else $error("unmapped read");
    a_sum_read: assert property (go && rd && addr == 8'h24
        |=> rdata == {20'h0, channel_irq_bits}) else $error("summary read");
endmodule // dcs_status_chk
bind dcs_status dcs_status_chk u_chk (.clk, .rstn, .ce, .addr, .rd, .rdata, .irq_en, .xfer_start,
    .act_done, .bus_err, .ch_disable, .pend_set, .trig_start, .channel_irq_bits,
    .channel_active_bits, .channel_waiting_bits);

/* verif/dcs_status_tb.sv */
// self-checking bench for the dma channel status block
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, s); failures++; end end
module dcs_status_tb;
    logic clk = 0;
    logic rstn = 0;
    logic wr = 0;
    logic rd = 0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic ce = 1'b1;
    logic [11:0] irq_en = 12'h0;
    logic [11:0] irq_o, act_o, wait_o;
    logic [11:0] e [10] = '{default: 12'h0};
    int failures = 0;
    int n_compared = 0;
    dcs_status dut (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .set_done(e[0]), .set_fault(e[1]), .set_suspend_flag(e[2]),
        .irq_en(irq_en), .xfer_start(e[3]), .act_done(e[4]), .bus_err(e[5]),
        .ch_disable(e[6]), .pend_set(e[7]), .trig_start(e[8]), .fetch_err(e[9]),
        .channel_irq_bits(irq_o), .channel_active_bits(act_o),
        .channel_waiting_bits(wait_o));
    initial forever #20 clk = ~clk;
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", x, rdata)
    endtask
    // select a channel, then read back in the very next cycle with no gap
    task automatic sel_rd(input logic [3:0] id, input logic [31:0] x);
        @(posedge clk);
        wr <= 1'b1;
        addr <= 8'h20;
        wdata <= {28'h0, id};
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", x, rdata)
    endtask
    // one-cycle event pulse on input group k
    task automatic ev(input int k, input logic [11:0] v);
        @(posedge clk);
        e[k] <= v;
        @(posedge clk);
        e[k] <= 12'h0;
    endtask
    task automatic give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 1; i < 4; i++)
            wr_reg(8'h20 + 8'(4 * i), 32'hffff_ffff);
        for (int i = 0; i < 4; i++)
            chk_rd(8'h20 + 8'(4 * i), 32'h0);
        chk_rd(8'h40, 32'h0);
        `CHK("vectors", 36'h0, {irq_o, act_o, wait_o})
        @(posedge clk);
        irq_en <= 12'hfff;
        ev(0, 12'h220);
        chk_rd(8'h24, 32'h220);
        `CHK("irq bits", 12'h220, irq_o)
        chk_rd(8'h20, 32'h205);
        ev(1, 12'h004);
        chk_rd(8'h20, 32'h102);
        wr_reg(8'h20, 32'h102);
        chk_rd(8'h20, 32'h205);
        wr_reg(8'h20, 32'h009);
        chk_rd(8'h20, 32'h209);
        wr_reg(8'h20, 32'h209);
        chk_rd(8'h20, 32'h205);
        ev(2, 12'h020);
        chk_rd(8'h20, 32'h605);
        wr_reg(8'h20, 32'h605);
        chk_rd(8'h20, 32'h0);
        ev(0, 12'h008);
        chk_rd(8'h24, 32'h008);
        @(posedge clk);
        irq_en <= 12'h0;
        chk_rd(8'h24, 32'h0);
        `CHK("irq bits", 12'h000, irq_o)
        wr_reg(8'h20, 32'h203);
        ev(3, 12'h807);
        chk_rd(8'h28, 32'h807);
        `CHK("busy bits", 12'h807, act_o)
        for (int i = 0; i < 3; i++)
            ev(4 + i, 12'h1 << i);
        chk_rd(8'h28, 32'h800);
        `CHK("busy bits", 12'h800, act_o)
        // a start while the clock enable is low must leave no trace
        @(posedge clk);
        ce <= 1'b0;
        ev(3, 12'h010);
        @(posedge clk);
        ce <= 1'b1;
        chk_rd(8'h28, 32'h800);
        `CHK("busy bits", 12'h800, act_o)
        ev(7, 12'h00e);
        chk_rd(8'h2c, 32'h00e);
        `CHK("waiting bits", 12'h00e, wait_o)
        ev(8, 12'h002);
        ev(5, 12'h004);
        ev(6, 12'h008);
        chk_rd(8'h2c, 32'h0);
        `CHK("waiting bits", 12'h000, wait_o)
        // pending, busy and fetch error of a channel with no interrupt flag
        ev(7, 12'h800);
        ev(9, 12'h800);
        sel_rd(4'hb, 32'he000);
        ev(6, 12'h800);
        sel_rd(4'hb, 32'h0000);
        `CHK("vectors", 36'h0, {irq_o, act_o, wait_o})
        // reset in mid-run with a channel busy
        ev(3, 12'h001);
        chk_rd(8'h28, 32'h001);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk_rd(8'h28, 32'h0);
        `CHK("vectors", 36'h0, {irq_o, act_o, wait_o})
        give_verdict();
    end
endmodule // dcs_status_tb
